// ===== rtl/psfd_consts.svh
// Purpose: Named constants of the power switch fault diagnosis block
// Assumes: Included by bare name from every design file that needs it
// Notes: Definitions only
`ifndef PSFD_CONSTS_SVH
`define PSFD_CONSTS_SVH

// =====================================================================
// Frame layout
`define PSFD_FRAME_BITS 4'h8
`define PSFD_CNT_INC 4'h1
`define PSFD_CLR_EDGE_CNT 4'h1
`define PSFD_LAST_EDGE_CNT 4'h7
`define PSFD_CMD_WR_BIT 7
`define PSFD_CMD_REG_BIT 6
`define PSFD_ADDR_HI 5
`define PSFD_ADDR_LO 4

// =====================================================================
// Register addresses and fields
`define PSFD_ADDR_PLCR 2'h1
`define PSFD_ADDR_DCR 2'h2
`define PSFD_ADDR_HARDWARE_CONFIG_COMMAND 2'h3
`define PSFD_HW_CTL_BIT 0
`define PSFD_OUT_HI 5
`define PSFD_FLD3_HI 2
`define PSFD_MUX_LIMIT 3'h6
`define PSFD_MUX_OFF 3'h7

// =====================================================================
// Reset values
`define PSFD_OUT_RST 6'h00
`define PSFD_LED_RST 3'h0
`define PSFD_MUX_RST 3'h7
`define PSFD_CH_ZERO 6'h00
`define PSFD_BYTE_ZERO 8'h00
`define PSFD_DIAG_PAD 2'h0
`define PSFD_DCR_PAD 4'h0

`endif

// ===== rtl/psfd_pkg.sv
// Purpose: Shared types of the power switch fault diagnosis block
// Assumes: Six channels, eight-bit frames
// Notes: Constants live in psfd_consts.svh
package psfd_pkg;
	typedef logic [5:0] psfd_ch_t;
	typedef logic [7:0] psfd_byte_t;
	typedef logic [2:0] psfd_mux_t;
	typedef logic [3:0] psfd_cnt_t;
endpackage

// ===== rtl/psfd_sync.sv
// Purpose: Two-flop level synchroniser, any width
// Assumes: Each bit is an independent level or a toggle
// Notes: Only the second stage may be read
`timescale 1ns/1ps
module psfd_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ===== rtl/psfd_top.sv
// Purpose: Fault latches, diagnosis word, sense routing and config of a six-channel switch
// Assumes: Eight-bit serial frames, data taken and driven on rising sclk edges
// Notes: Registers live on mclk; the sclk side only shifts and signals frame events
// How it works
// RULE1 - Clear-thermal-latch bit written zero leaves every thermal latch unchanged.
// RULE2 - Clear-thermal-latch bit written one clears all thermal latches together; code clears the gate latches at once, the error-flag ones next frame.
// RULE3 - Reported error flag is thermal flag OR latched over-load flag.
// RULE4 - Over-load monitor latches into error flag, cleared per diagnosis word sent.
// RULE5 - Over-load clear happens after second rising edge of the diagnosis frame.
// RULE6 - Over-temperature sets a gate latch holding the channel off until cleared.
// RULE7 - Gate thermal latch is kept separate from the error-flag thermal latch.
// RULE8 - Thermal flag sets and holds even with the channel commanded off.
// RULE9 - Thermal part of error flag clears only during the next frame.
// RULE10 - After that deferred clear the flag latches new faults again.
// RULE11 - First diagnosis after clear command still shows previously latched channels.
// RULE12 - Persisting over-load sets the error flag again right after a clear.
// RULE13 - Dynamic shutdown while commanded on reports error and sense off.
// RULE14 - Sense output carries exactly one channel chosen by the multiplexer field.
// RULE15 - Sense output can be disabled entirely by a multiplexer setting.
// RULE16 - Bypass monitor result for the selected channel is readable.
// RULE17 - Channel on-command bit one switches on, zero switches off.
// RULE18 - Dynamic shutdown error clears when read and sets again if still active.
// RULE19 - Over-current or over-temperature removes the channel from the sense output.
// RULE20 - Host writes upper config bits as zero; reset bit has no effect.
// RULE21 - A set thermal latch forces the channel off regardless of its command.
`timescale 1ns/1ps
`include "psfd_consts.svh"
module psfd_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Fault monitors, one bit per channel
	input wire psfd_pkg::psfd_ch_t otemp_in,
	input wire psfd_pkg::psfd_ch_t ovl_in,
	input wire psfd_pkg::psfd_ch_t dts_in,
	input wire psfd_pkg::psfd_ch_t vds_low_in,
	// Power stage control
	output psfd_pkg::psfd_ch_t gate_on,
	output logic [2:0] led_mode_select,
	// Current sense pin
	output psfd_pkg::psfd_ch_t sense_en,
	output logic sense_oe
);
	import psfd_pkg::*;

	function automatic psfd_ch_t psfd_sel(input psfd_mux_t m);
		psfd_ch_t r;
		r = `PSFD_CH_ZERO;
		if (m < `PSFD_MUX_LIMIT)
			r[m] = 1'b1;
		return r;
	endfunction

	// =================================================================
	// Link side, clocked by sclk
	psfd_cnt_t bit_cnt_reg;
	psfd_cnt_t bit_cnt_next;
	psfd_byte_t rx_reg;
	psfd_byte_t cmd_hold_reg;
	psfd_byte_t tx_word_reg;
	logic miso_reg;
	logic miso_oe_reg;
	logic edge2_tgl_reg;
	logic edge8_tgl_reg;
	logic frame_live;
	logic [2:0] tx_idx;

	assign frame_live = bit_cnt_reg < `PSFD_FRAME_BITS;
	assign bit_cnt_next = frame_live ? bit_cnt_reg + `PSFD_CNT_INC : bit_cnt_reg;
	assign tx_idx = 3'(`PSFD_LAST_EDGE_CNT) - bit_cnt_reg[2:0];

	// Frame state dies with chip select, so a stopped clock leaves nothing half done
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= 4'h0;
			miso_oe_reg <= 1'b0;
			miso_reg <= 1'b0;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			miso_oe_reg <= 1'b1;
			miso_reg <= frame_live ? tx_word_reg[tx_idx] : 1'b0;
		end
	end

	always_ff @(posedge sclk) begin
		rx_reg <= {rx_reg[6:0], mosi};
	end

	// Toggles cross to mclk; tx_word_reg and cmd_hold_reg are held stable meanwhile
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			edge2_tgl_reg <= 1'b0;
			edge8_tgl_reg <= 1'b0;
			cmd_hold_reg <= `PSFD_BYTE_ZERO;
		end else begin
			if (!cs_n && bit_cnt_reg == `PSFD_CLR_EDGE_CNT)
				edge2_tgl_reg <= ~edge2_tgl_reg; // [RULE5]
			if (!cs_n && bit_cnt_reg == `PSFD_LAST_EDGE_CNT) begin
				edge8_tgl_reg <= ~edge8_tgl_reg;
				cmd_hold_reg <= {rx_reg[6:0], mosi};
			end
		end
	end

	assign miso = miso_reg;
	assign miso_oe = miso_oe_reg;

	// =================================================================
	// Crossings into mclk
	logic [2:0] link_s;
	psfd_ch_t otemp_s;
	psfd_ch_t ovl_s;
	psfd_ch_t dts_s;
	psfd_ch_t vds_s;
	logic cs_s;
	logic e2_prev_reg;
	logic e8_prev_reg;
	logic e2_pulse;
	logic e8_pulse;

	psfd_sync #(.W(3)) u_link_sync (
		.clk(mclk),
		.rst(rst),
		.d({cs_n, edge2_tgl_reg, edge8_tgl_reg}),
		.q(link_s)
	);

	psfd_sync #(.W(24)) u_fault_sync (
		.clk(mclk),
		.rst(rst),
		.d({otemp_in, ovl_in, dts_in, vds_low_in}),
		.q({otemp_s, ovl_s, dts_s, vds_s})
	);

	assign cs_s = link_s[2];
	assign e2_pulse = link_s[1] ^ e2_prev_reg;
	assign e8_pulse = link_s[0] ^ e8_prev_reg;

	// =================================================================
	// Command decode
	logic cmd_wr;
	logic cmd_reg;
	logic [1:0] cmd_addr;
	logic out_wr;
	logic plcr_wr;
	logic dcr_wr;
	logic hardware_config_command_wr;
	logic ctl_cmd;
	logic dcr_rd;

	assign cmd_wr = cmd_hold_reg[`PSFD_CMD_WR_BIT];
	assign cmd_reg = cmd_hold_reg[`PSFD_CMD_REG_BIT];
	assign cmd_addr = cmd_hold_reg[`PSFD_ADDR_HI:`PSFD_ADDR_LO];
	assign out_wr = e8_pulse && cmd_wr && !cmd_reg;
	assign plcr_wr = e8_pulse && cmd_wr && cmd_reg && cmd_addr == `PSFD_ADDR_PLCR;
	assign dcr_wr = e8_pulse && cmd_wr && cmd_reg && cmd_addr == `PSFD_ADDR_DCR;
	assign hardware_config_command_wr = e8_pulse && cmd_wr && cmd_reg && cmd_addr == `PSFD_ADDR_HARDWARE_CONFIG_COMMAND;
	// Only the clear bit acts; the reset bit and upper bits are ignored
	assign ctl_cmd = hardware_config_command_wr && cmd_hold_reg[`PSFD_HW_CTL_BIT]; // [RULE1] [RULE2] [RULE20]
	assign dcr_rd = e8_pulse && !cmd_wr && cmd_reg && cmd_addr == `PSFD_ADDR_DCR;

	// =================================================================
	// Fault latches and next values
	psfd_ch_t on_cmd_reg;
	psfd_ch_t thr_latch_reg;
	psfd_ch_t thr_latch_next;
	psfd_ch_t err_ovl_reg;
	psfd_ch_t err_ovl_next;
	psfd_ch_t err_thr_reg;
	psfd_ch_t err_thr_next;
	psfd_ch_t ovl_mon;
	psfd_ch_t err_flag;
	psfd_ch_t mux_sel;
	psfd_ch_t gate_next;
	psfd_ch_t sense_next;
	psfd_mux_t mux_reg;
	psfd_byte_t tx_next;
	logic [2:0] led_reg;
	logic answer_dcr_reg;
	logic ctl_pend_reg;
	logic sbm_reg;
	logic ovl_clr;
	logic thr_clr;

	// Dynamic shutdown of a commanded-on channel rides on the over-load path
	assign ovl_mon = ovl_s | (dts_s & on_cmd_reg); // [RULE13] [RULE18]
	assign ovl_clr = e2_pulse && !answer_dcr_reg; // [RULE4] [RULE5]
	assign thr_clr = e2_pulse && ctl_pend_reg; // [RULE9]
	// Set beats clear, so a fault that persists is seen again at once
	assign err_ovl_next = (err_ovl_reg & ~{6{ovl_clr}}) | ovl_mon; // [RULE4] [RULE12] [RULE18]
	assign err_thr_next = (err_thr_reg & ~{6{thr_clr}}) | otemp_s; // [RULE8] [RULE9] [RULE10]
	// Second copy of thermal state, kept at the gates
	assign thr_latch_next = (thr_latch_reg & ~{6{ctl_cmd}}) | otemp_s; // [RULE2] [RULE6] [RULE7]
	assign err_flag = err_thr_reg | err_ovl_reg; // [RULE3]
	assign mux_sel = psfd_sel(mux_reg); // [RULE14] [RULE15]
	assign gate_next = on_cmd_reg & ~thr_latch_reg & ~otemp_s & ~dts_s; // [RULE17] [RULE21]
	// A limited channel is dropped from the sense pin but stays switched on
	assign sense_next = mux_sel & gate_next & ~ovl_s; // [RULE14] [RULE19]

	// =================================================================
	// Answer word and register next values
	logic sbm_next;
	logic ctl_pend_next;
	logic answer_dcr_next;
	psfd_byte_t diag_word;
	psfd_byte_t dcr_word;
	psfd_ch_t gate_reg;
	psfd_ch_t sense_reg;
	logic sense_oe_reg;
	psfd_ch_t on_cmd_next;
	psfd_mux_t mux_next;
	logic [2:0] led_next;

	// The bypass flag is raised when the selected switch does not report a low drop (vds_low_in clear)
	assign sbm_next = |(mux_sel & ~vds_s); // [RULE16]
	assign diag_word = {`PSFD_DIAG_PAD, err_flag}; // [RULE3]
	assign dcr_word = {`PSFD_DCR_PAD, sbm_reg, mux_reg}; // [RULE16]
	// Frozen while a frame runs, so the word after a clear still shows old faults;
	// a fault arriving within two mclk cycles of chip select falling waits a frame
	assign tx_next = !cs_s ? tx_word_reg : (answer_dcr_reg ? dcr_word : diag_word); // [RULE11]
	assign ctl_pend_next = ctl_cmd ? 1'b1 : (thr_clr ? 1'b0 : ctl_pend_reg); // [RULE9]
	assign answer_dcr_next = e8_pulse ? dcr_rd : answer_dcr_reg;
	assign on_cmd_next = out_wr ? cmd_hold_reg[`PSFD_OUT_HI:0] : on_cmd_reg; // [RULE17]
	assign mux_next = dcr_wr ? cmd_hold_reg[`PSFD_FLD3_HI:0] : mux_reg; // [RULE14] [RULE15]
	assign led_next = plcr_wr ? cmd_hold_reg[`PSFD_FLD3_HI:0] : led_reg;

	// =================================================================
	// Registers on mclk
	always_ff @(posedge mclk) begin
		if (rst) begin
			e2_prev_reg <= 1'b0;
			e8_prev_reg <= 1'b0;
			on_cmd_reg <= `PSFD_OUT_RST;
			mux_reg <= `PSFD_MUX_RST;
			led_reg <= `PSFD_LED_RST;
			answer_dcr_reg <= 1'b0;
			ctl_pend_reg <= 1'b0;
		end else begin
			e2_prev_reg <= link_s[1];
			e8_prev_reg <= link_s[0];
			on_cmd_reg <= on_cmd_next;
			mux_reg <= mux_next;
			led_reg <= led_next;
			answer_dcr_reg <= answer_dcr_next;
			ctl_pend_reg <= ctl_pend_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			thr_latch_reg <= `PSFD_CH_ZERO;
			err_ovl_reg <= `PSFD_CH_ZERO;
			err_thr_reg <= `PSFD_CH_ZERO;
			sbm_reg <= 1'b0;
			tx_word_reg <= `PSFD_BYTE_ZERO;
		end else begin
			thr_latch_reg <= thr_latch_next;
			err_ovl_reg <= err_ovl_next;
			err_thr_reg <= err_thr_next;
			sbm_reg <= sbm_next;
			tx_word_reg <= tx_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			gate_reg <= `PSFD_CH_ZERO;
			sense_reg <= `PSFD_CH_ZERO;
			sense_oe_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			sense_reg <= sense_next;
			sense_oe_reg <= |sense_next;
		end
	end

	assign gate_on = gate_reg;
	assign led_mode_select = led_reg;
	assign sense_en = sense_reg;
	assign sense_oe = sense_oe_reg;

	// =================================================================
	// Checks
	sequence s_ctl_zero;
		hardware_config_command_wr && !cmd_hold_reg[`PSFD_HW_CTL_BIT];
	endsequence

	sequence s_thr_clear;
		e2_pulse && ctl_pend_reg;
	endsequence

	property p_ctl_zero_keeps;
		@(posedge mclk) disable iff (rst)
		s_ctl_zero |=> (thr_latch_reg & $past(thr_latch_reg)) == $past(thr_latch_reg);
	endproperty
	a_ctl_zero_keeps: assert property (p_ctl_zero_keeps) // [RULE1]
		else $error("thermal latch lost on a zero clear bit");

	property p_ctl_one_clears;
		@(posedge mclk) disable iff (rst)
		(ctl_cmd && otemp_s == `PSFD_CH_ZERO) |=> thr_latch_reg == `PSFD_CH_ZERO;
	endproperty
	a_ctl_one_clears: assert property (p_ctl_one_clears) // [RULE2]
		else $error("thermal latch kept after clear command");

	property p_diag_or;
		@(posedge mclk) disable iff (rst)
		(cs_s && !answer_dcr_reg) |=>
			tx_word_reg == {`PSFD_DIAG_PAD, $past(err_thr_reg) | $past(err_ovl_reg)};
	endproperty
	a_diag_or: assert property (p_diag_or) // [RULE3]
		else $error("diagnosis word is not the OR of both flags");

	property p_ovl_holds;
		@(posedge mclk) disable iff (rst)
		!ovl_clr |=> (err_ovl_reg & $past(err_ovl_reg)) == $past(err_ovl_reg);
	endproperty
	a_ovl_holds: assert property (p_ovl_holds) // [RULE4]
		else $error("over-load flag dropped without a diagnosis word");

	property p_clear_edge2;
		@(posedge sclk) disable iff (rst || cs_n)
		bit_cnt_reg == `PSFD_CLR_EDGE_CNT |=> edge2_tgl_reg != $past(edge2_tgl_reg);
	endproperty
	a_clear_edge2: assert property (p_clear_edge2) // [RULE5]
		else $error("clear event not raised at the second edge");

	property p_gate_thermal_off;
		@(posedge mclk) disable iff (rst)
		(|thr_latch_reg) |=> (gate_reg & $past(thr_latch_reg)) == `PSFD_CH_ZERO;
	endproperty
	a_gate_thermal_off: assert property (p_gate_thermal_off) // [RULE21]
		else $error("latched channel still switched on");

	property p_thr_not_in_cmd;
		@(posedge mclk) disable iff (rst)
		ctl_cmd |=> (err_thr_reg & $past(err_thr_reg)) == $past(err_thr_reg);
	endproperty
	a_thr_not_in_cmd: assert property (p_thr_not_in_cmd) // [RULE9]
		else $error("thermal flag cleared within the command frame");

	property p_thr_rearm;
		@(posedge mclk) disable iff (rst)
		s_thr_clear |=> err_thr_reg == $past(otemp_s);
	endproperty
	a_thr_rearm: assert property (p_thr_rearm) // [RULE10]
		else $error("thermal flag wrong after deferred clear");
endmodule

// ===== verif/psfd_host.sv
// Purpose: Serial host model sending eight-bit frames
// Assumes: sclk idles low, MSB first
// Notes: sclk runs only inside frames
`timescale 1ns/1ps
module psfd_host (
	// Serial link
	output logic sclk = 1'b0,
	output logic cs_n = 1'b1,
	output logic mosi = 1'b0,
	input wire logic miso
);
	// ==========
	// Frame
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#7.5 sclk = 1'b1;
			// The device drives each bit on the rising edge, so take it half a period later
			#7.5 rx[i] = miso;
			sclk = 1'b0;
		end
		#7.5 cs_n = 1'b1;
		// Released line must not keep its last bit
		mosi = ~mosi;
		#30;
	endtask
endmodule

// ===== verif/psfd_top_test.sv
// Purpose: Self-checking bench of the fault diagnosis block
// Assumes: A frame after a write answers with the diagnosis word
// Notes: Patterns from an LFSR with a fixed seed
`timescale 1ns/1ps
module psfd_top_test;
	import psfd_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sclk, cs_n, mosi, miso, oe, moe;
	logic [2:0] led;
	psfd_ch_t ot = 6'h00, ov = 6'h00, dt = 6'h00, vl = 6'h00;
	psfd_ch_t gate, sen, v, mask;
	logic [7:0] rx;
	logic [31:0] lfsr = 32'h00012C6B;
	logic [2:0] c;
	int err_count = 0;
	int cmp_count = 0;
	always #10 mclk = ~mclk;
	psfd_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	psfd_top dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso), .miso_oe(moe), .otemp_in(ot), .ovl_in(ov),
		.dts_in(dt), .vds_low_in(vl), .gate_on(gate), .led_mode_select(led),
		.sense_en(sen), .sense_oe(oe));
	// ==========
	// Helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic psfd_ch_t exp_sense(input logic [2:0] m, input psfd_ch_t on);
		return (m < 3'h6) ? (on & (6'h01 << m)) : 6'h00;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d of %0d checks", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Margin for the two-flop crossing into mclk
	task automatic fr(input logic [7:0] tx);
		host.xfer(tx, rx);
		cyc(6);
	endtask
	task automatic fx(input psfd_ch_t e);
		fr(8'h80 | {2'h0, v});
		chk(rx, {2'h0, e});
	endtask
	// ==========
	// Scenarios
	initial begin
		cyc(16);
		rst = 1'b0;
		lfsr = nxt(nxt(lfsr));
		c = lfsr[8:6] % 3'h6;
		mask = 6'h01 << c;
		v = lfsr[5:0] | mask;
		vl = lfsr[14:9];
		cyc(2);
		chk(gate, 8'h00);
		chk(sen, 8'h00);
		chk(8'(moe), 8'h00);
		fr(8'hD0 | {5'h00, lfsr[17:15]});
		chk(8'(led), 8'(lfsr[17:15]));
		fx(6'h00);
		chk(gate, v);
		for (int m = 0; m < 8; m++) begin
			fr(8'hE0 | 8'(m));
			chk(sen, exp_sense(3'(m), v));
			chk(oe, |exp_sense(3'(m), v));
		end
		fr(8'hE0 | {5'h00, c});
		// Read request for the diagnosis control word, answered in the next frame
		fr(8'h60);
		fr(8'h80 | {2'h0, v});
		chk(rx, {4'h0, ~vl[c], c});
		ot[c] = 1'b1;
		cyc(4);
		ot = 6'h00;
		cyc(4);
		chk(gate, v & ~mask);
		chk(sen, 8'h00);
		// Upper data bits stay zero
		fr(8'hF0);
		chk(rx, {2'h0, mask});
		chk(gate, v & ~mask);
		fr(8'hF1);
		chk(gate, v);
		fx(mask);
		fx(6'h00);
		ov[c] = 1'b1;
		cyc(4);
		chk(sen, 8'h00);
		fx(mask);
		fx(mask);
		ov = 6'h00;
		fx(mask);
		fx(6'h00);
		dt[c] = 1'b1;
		cyc(4);
		fx(mask);
		chk(sen, 8'h00);
		fx(mask);
		dt = 6'h00;
		cyc(4);
		fx(mask);
		fx(6'h00);
		give_verdict();
	end
	initial begin
		#50000;
		err_count++;
		give_verdict();
	end
endmodule
